//--- inc/sgw_consts.vh
`ifndef SGW_CONSTS_VH
`define SGW_CONSTS_VH
// i/o addresses (16-bit i/o space)
`define SGW_IDX_PORT_A 16'h002E
`define SGW_DAT_PORT_A 16'h002F
`define SGW_IDX_PORT_B 16'h004E
`define SGW_DAT_PORT_B 16'h004F
`define SGW_WDT_CTRL_PORT 16'h0300
`define SGW_WDT_CNT_PORT 16'h0301
// entry and exit keys
`define SGW_KEY_ENTER_A 8'h87
`define SGW_KEY_ENTER_B 8'h77
`define SGW_KEY_EXIT 8'hAA
// configuration indices
`define SGW_IDX_LDSEL 8'h07
`define SGW_IDX_ACTIVATE 8'h30
`define SGW_IDX_GPIO_DIR 8'hF0
`define SGW_IDX_GPIO_VAL 8'hF1
`define SGW_IDX_GPIO_POL 8'hF2
`define SGW_LDN_GPIO 8'h07
`define SGW_LDN_WDT 8'h08
// reset values
`define SGW_GPIO_DIR_RST 8'hFF
`define SGW_GPIO_VAL_RST 8'h00
`define SGW_GPIO_POL_RST 8'h00
`define SGW_ACT_RST 8'h00
`define SGW_LDSEL_RST 8'h00
`define SGW_UNIT_RST 8'h03
// watchdog unit codes
`define SGW_UNIT_10MS 8'h00
`define SGW_UNIT_1S 8'h03
`define SGW_UNIT_1MIN 8'h05
// timing: clock period in ns and unit lengths in ns
`define SGW_CLK_NS 50
`define SGW_T_10MS_NS 10000000
`define SGW_T_1S_NS 1000000000
// minute is sixty seconds, counted as sixty one-second ticks
`define SGW_MIN_SECS 60
`define SGW_MIN_LAST 6'h3B
`define SGW_TICKS_10MS (`SGW_T_10MS_NS / `SGW_CLK_NS)
`define SGW_TICKS_1S (`SGW_T_1S_NS / `SGW_CLK_NS)
`endif

//--- src/sgw_cfg_regs.v
`timescale 1ns/1ps
`include "sgw_consts.vh"
// ****************************************
// gpio bank: direction, value, polarity
// ****************************************
module sgw_cfg_regs (
    ref_clk,
    resetn,
    wr_en,
    wr_sel,
    wr_data,
    pin_in,
    dir_q,
    val_q,
    pol_q,
    pin_out,
    pin_oe_n,
    val_view
);
    input wire ref_clk;
    input wire resetn;
    input wire wr_en;
    input wire [1:0] wr_sel;
    input wire [7:0] wr_data;
    input wire [7:0] pin_in;
    output reg [7:0] dir_q;
    output reg [7:0] val_q;
    output reg [7:0] pol_q;
    output reg [7:0] pin_out;
    output reg [7:0] pin_oe_n;
    output wire [7:0] val_view;

    localparam [7:0] DIR_RST = `SGW_GPIO_DIR_RST;
    localparam [7:0] VAL_RST = `SGW_GPIO_VAL_RST;
    localparam [7:0] POL_RST = `SGW_GPIO_POL_RST;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_bit
            // input lines read the pin through the polarity; outputs read back the latch
            assign val_view[g] = dir_q[g] ? (pin_in[g] ^ pol_q[g]) : val_q[g];

            always @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    dir_q[g] <= DIR_RST[g];
                    val_q[g] <= VAL_RST[g];
                    pol_q[g] <= POL_RST[g];
                    pin_out[g] <= VAL_RST[g] ^ POL_RST[g];
                    pin_oe_n[g] <= DIR_RST[g];
                end else begin
                    if (wr_en && wr_sel == 2'h0)
                        dir_q[g] <= wr_data[g];
                    // writes to input-direction bits are dropped
                    if (wr_en && wr_sel == 2'h1 && !dir_q[g])
                        val_q[g] <= wr_data[g];
                    if (wr_en && wr_sel == 2'h2)
                        pol_q[g] <= wr_data[g];
                    pin_out[g] <= val_q[g] ^ pol_q[g];
                    pin_oe_n[g] <= dir_q[g];
                end
            end
        end
    endgenerate
endmodule // sgw_cfg_regs

//--- src/sgw_top.v
`timescale 1ns/1ps
`include "sgw_consts.vh"
module sgw_top #(
    parameter [31:0] TICKS_10MS = `SGW_TICKS_10MS,
    parameter [31:0] TICKS_1S = `SGW_TICKS_1S
) (
    ref_clk,
    resetn,
    io_addr,
    io_wdata,
    io_wr,
    io_rd,
    io_rdata,
    io_rd_hit,
    gpio_in,
    gpio_out,
    gpio_oe_n,
    wdt_irq_mode,
    cpu_reset_req,
    wdt_irq,
    wdt_timeout
);
    input wire ref_clk;
    input wire resetn;
    input wire [15:0] io_addr;
    input wire [7:0] io_wdata;
    input wire io_wr;
    input wire io_rd;
    output reg [7:0] io_rdata;
    output wire io_rd_hit;
    input wire [7:0] gpio_in;
    output wire [7:0] gpio_out;
    output wire [7:0] gpio_oe_n;
    input wire wdt_irq_mode;
    output reg cpu_reset_req;
    output reg wdt_irq;
    output wire wdt_timeout;

    // ****************************************
    // configuration key state machine
    // ****************************************
    localparam [2:0] ST_LOCKED = 3'b001;
    localparam [2:0] ST_HALF = 3'b010;
    localparam [2:0] ST_OPEN = 3'b100;

    function is_idx;
        input [15:0] a;
        begin
            is_idx = (a == `SGW_IDX_PORT_A) || (a == `SGW_IDX_PORT_B);
        end
    endfunction

    function is_dat;
        input [15:0] a;
        begin
            is_dat = (a == `SGW_DAT_PORT_A) || (a == `SGW_DAT_PORT_B);
        end
    endfunction

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [7:0] key_reg;
    reg [7:0] index_reg;
    reg [7:0] ldsel_reg;
    reg [7:0] act_reg;
    reg [7:0] unit_reg;
    reg [7:0] count_reg;
    reg running_reg;
    reg timeout_reg;
    reg [31:0] tick_reg;
    reg [5:0] min_reg;

    wire idx_wr = io_wr && is_idx(io_addr);
    wire dat_wr = io_wr && is_dat(io_addr) && state_reg == ST_OPEN;
    wire dat_rd = io_rd && is_dat(io_addr) && state_reg == ST_OPEN;
    wire is_enter_key = (io_wdata == `SGW_KEY_ENTER_A) ||
        ((io_wdata == `SGW_KEY_ENTER_B) && (io_addr == `SGW_IDX_PORT_B));
    wire wdt_on = act_reg[0];
    wire ctl_wr = io_wr && wdt_on && io_addr == `SGW_WDT_CTRL_PORT;
    wire cnt_wr = io_wr && wdt_on && io_addr == `SGW_WDT_CNT_PORT;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_LOCKED: begin
                if (idx_wr && is_enter_key)
                    state_next = ST_HALF;
            end
            ST_HALF: begin
                // second key must match the first and come next
                if (idx_wr)
                    state_next = (io_wdata == key_reg) ? ST_OPEN : ST_LOCKED;
                else if (io_wr || io_rd)
                    state_next = ST_LOCKED;
            end
            ST_OPEN: begin
                if (idx_wr && io_wdata == `SGW_KEY_EXIT)
                    state_next = ST_LOCKED;
            end
            default: state_next = ST_LOCKED;
        endcase
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_LOCKED;
            key_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            // the last index write seen while locked is what the second write must repeat
            if (state_reg == ST_LOCKED && idx_wr)
                key_reg <= io_wdata;
        end
    end

    // ****************************************
    // index, device select, activation
    // ****************************************
    wire in_gpio = ldsel_reg == `SGW_LDN_GPIO;
    wire in_wdt = ldsel_reg == `SGW_LDN_WDT;
    // the exit key is not taken as an index, so a new session finds the old one
    wire open_idx_wr = idx_wr && state_reg == ST_OPEN && io_wdata != `SGW_KEY_EXIT;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            index_reg <= 8'h00;
            ldsel_reg <= `SGW_LDSEL_RST;
            act_reg <= `SGW_ACT_RST;
        end else begin
            if (open_idx_wr)
                index_reg <= io_wdata;
            if (dat_wr && index_reg == `SGW_IDX_LDSEL)
                ldsel_reg <= io_wdata;
            if (dat_wr && in_wdt && index_reg == `SGW_IDX_ACTIVATE)
                act_reg <= io_wdata;
        end
    end

    // ****************************************
    // gpio bank
    // ****************************************
    // index low bits pick the bank register: F0h direction, F1h value, F2h polarity
    function is_gpio_idx;
        input [7:0] i;
        begin
            is_gpio_idx = (i == `SGW_IDX_GPIO_DIR) || (i == `SGW_IDX_GPIO_VAL) ||
                (i == `SGW_IDX_GPIO_POL);
        end
    endfunction

    wire gpio_wr = dat_wr && in_gpio && is_gpio_idx(index_reg);
    wire [1:0] gpio_sel = index_reg[1:0];
    wire [7:0] dir_q;
    wire [7:0] val_q;
    wire [7:0] pol_q;
    wire [7:0] val_view;

    sgw_cfg_regs u_gpio (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .wr_en(gpio_wr),
        .wr_sel(gpio_sel),
        .wr_data(io_wdata),
        .pin_in(gpio_in),
        .dir_q(dir_q),
        .val_q(val_q),
        .pol_q(pol_q),
        .pin_out(gpio_out),
        .pin_oe_n(gpio_oe_n),
        .val_view(val_view)
    );

    // ****************************************
    // read path
    // ****************************************
    reg [7:0] rd_mux;
    assign io_rd_hit = dat_rd;

    always @* begin
        rd_mux = 8'h00;
        if (index_reg == `SGW_IDX_LDSEL)
            rd_mux = ldsel_reg;
        else if (in_wdt && index_reg == `SGW_IDX_ACTIVATE)
            rd_mux = act_reg;
        else if (in_gpio && index_reg == `SGW_IDX_GPIO_DIR)
            rd_mux = dir_q;
        else if (in_gpio && index_reg == `SGW_IDX_GPIO_VAL)
            rd_mux = val_view;
        else if (in_gpio && index_reg == `SGW_IDX_GPIO_POL)
            rd_mux = pol_q;
    end

    // a refused read leaves the last data standing on io_rdata
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            io_rdata <= 8'h00;
        else if (dat_rd)
            io_rdata <= rd_mux;
    end

    // ****************************************
    // watchdog
    // ****************************************
    // unknown unit codes fall back to one second, the safest long base
    function [31:0] unit_len;
        input [7:0] u;
        begin
            if (u == `SGW_UNIT_10MS)
                unit_len = TICKS_10MS;
            else
                unit_len = TICKS_1S;
        end
    endfunction

    wire [31:0] unit_ticks = unit_len(unit_reg);
    wire is_min = unit_reg == `SGW_UNIT_1MIN;
    wire tick_end = tick_reg >= unit_ticks - 32'h0000_0001;
    wire min_end = !is_min || min_reg == `SGW_MIN_LAST;
    wire unit_pulse = running_reg && tick_end && min_end;
    // last unit of a loaded count; a deactivated function never expires
    wire expire_now = unit_pulse && count_reg == 8'h01 && wdt_on;
    assign wdt_timeout = timeout_reg;

    // deactivation stops the count but leaves the flag for the host to read
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            unit_reg <= `SGW_UNIT_RST;
            count_reg <= 8'h00;
            running_reg <= 1'b0;
        end else begin
            if (ctl_wr)
                unit_reg <= io_wdata;
            if (!wdt_on) begin
                running_reg <= 1'b0;
            end else if (cnt_wr) begin
                count_reg <= io_wdata;
                running_reg <= io_wdata != 8'h00;
            end else if (unit_pulse) begin
                count_reg <= count_reg - 8'h01;
                if (count_reg == 8'h01)
                    running_reg <= 1'b0;
            end
        end
    end

    // unit prescaler; a fresh count always starts on a whole unit
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tick_reg <= 32'h0000_0000;
            min_reg <= 6'h00;
        end else if (!wdt_on || cnt_wr) begin
            tick_reg <= 32'h0000_0000;
            min_reg <= 6'h00;
        end else if (running_reg) begin
            tick_reg <= tick_end ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
            if (tick_end && is_min)
                min_reg <= min_end ? 6'h00 : min_reg + 6'h01;
        end
    end

    // ****************************************
    // expiry status and actions
    // ****************************************
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            timeout_reg <= 1'b0;
        end else begin
            // expiry in the clearing cycle wins, so no timeout is lost
            if (expire_now)
                timeout_reg <= 1'b1;
            else if (ctl_wr)
                timeout_reg <= 1'b0;
        end
    end

    // the reset request is one cycle wide; the interrupt is a level that
    // follows the flag until the host rewrites the control register
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_reset_req <= 1'b0;
            wdt_irq <= 1'b0;
        end else begin
            cpu_reset_req <= expire_now && !wdt_irq_mode;
            wdt_irq <= wdt_irq_mode && (timeout_reg || expire_now) && !ctl_wr;
        end
    end
endmodule // sgw_top

//--- tb/sgw_chk.sv
`timescale 1ns/1ps
// ****************
// bus, gpio pin and watchdog checks
// ****************
module sgw_chk (
    input wire ref_clk,
    input wire resetn,
    input wire [15:0] io_addr,
    input wire [7:0] io_wdata,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_rdata,
    input wire io_rd_hit,
    input wire [7:0] gpio_out,
    input wire [7:0] gpio_oe_n,
    input wire cpu_reset_req,
    input wire wdt_irq,
    input wire wdt_timeout
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence key_twice;
        io_wr && io_addr == 16'h002e && io_wdata == 8'h87 ##1
        io_wr && io_addr == 16'h002e && io_wdata == 8'h87;
    endsequence
    sequence exit_key;
        io_wr && io_addr == 16'h002e && io_wdata == 8'haa;
    endsequence
    sequence data_rd;
        io_rd && io_addr == 16'h002f;
    endsequence
    hit_decode_a: assert property (io_rd_hit |-> io_rd &&
        (io_addr == 16'h002f || io_addr == 16'h004f)) else $error("stray read hit");
    rdata_hold_a: assert property (!$past(io_rd_hit) |-> $stable(io_rdata))
        else $error("read data moved without a read");
    enter_open_a: assert property (key_twice ##1 data_rd |-> io_rd_hit)
        else $error("double key did not open");
    exit_shut_a: assert property (exit_key ##1 data_rd |-> !io_rd_hit)
        else $error("exit key did not close");
    pins_move_a: assert property ($changed(gpio_out) || $changed(gpio_oe_n)
        |-> $past(io_wr, 2)) else $error("pins moved without a write");
    flag_clear_a: assert property ($fell(wdt_timeout)
        |-> $past(io_wr && io_addr == 16'h0300)) else $error("flag dropped alone");
    expire_act_a: assert property ($rose(wdt_timeout) |-> cpu_reset_req || wdt_irq)
        else $error("expiry without action");
    rst_pulse_a: assert property (cpu_reset_req |-> wdt_timeout ##1 !cpu_reset_req)
        else $error("reset request not a pulse");
    irq_cause_a: assert property ($rose(wdt_irq) |-> wdt_timeout)
        else $error("irq without timeout");
endmodule // sgw_chk

//--- tb/sgw_host.sv
`timescale 1ns/1ps
// ****************
// host i/o cycles, launched just after a rising edge
// ****************
module sgw_host (
    input wire ref_clk,
    output reg [15:0] io_addr,
    output reg [7:0] io_wdata,
    output reg io_wr,
    output reg io_rd
);
    initial begin
        io_addr = 16'h0000;
        io_wdata = 8'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
    end
    // strobe is left high so back to back cycles need no idle edge
    task automatic wr(input [15:0] a, input [7:0] d);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        io_rd <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input [15:0] a);
        io_addr <= a;
        io_wdata <= ~io_wdata;
        io_wr <= 1'b0;
        io_rd <= 1'b1;
        @(posedge ref_clk);
    endtask
    task automatic idle(input int n);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        io_addr <= ~io_addr;
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic enter(input [15:0] a, input [7:0] k);
        wr(a, k);
        wr(a, k);
    endtask
    task automatic leave(input [15:0] a);
        wr(a, 8'haa);
    endtask
    task automatic cfg(input [15:0] a, input [7:0] i, input [7:0] d);
        wr(a, i);
        wr(a + 16'h0001, d);
    endtask
endmodule // sgw_host

//--- tb/superio_gpio_watchdog_tb_top.sv
`timescale 1ns/1ps
// ****************
// bench top
// ****************
module superio_gpio_watchdog_tb_top;
    localparam int T10 = 4;
    localparam int T1S = 10;
    reg ref_clk = 1'b0;
    reg resetn = 1'b0;
    reg [7:0] gpio_in = 8'h00;
    reg wdt_irq_mode = 1'b0;
    wire [15:0] io_addr;
    wire [7:0] io_wdata, io_rdata, gpio_out, gpio_oe_n;
    wire io_wr, io_rd, io_rd_hit, cpu_reset_req, wdt_irq, wdt_timeout;
    int fail_count = 0;
    int num_checks = 0;
    int c;
    int tk[3] = '{T10, T1S, 60 * T1S};
    reg [7:0] uc[3] = '{8'h00, 8'h03, 8'h05};
    reg [7:0] exp_q[$];
    reg hit_d = 1'b0;
    reg [7:0] v, p, g;
    initial forever #25 ref_clk = ~ref_clk;
    sgw_host host (.ref_clk(ref_clk), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wr(io_wr), .io_rd(io_rd));
    sgw_top #(.TICKS_10MS(T10), .TICKS_1S(T1S)) dut (.ref_clk(ref_clk), .resetn(resetn),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
        .io_rdata(io_rdata), .io_rd_hit(io_rd_hit), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe_n(gpio_oe_n), .wdt_irq_mode(wdt_irq_mode), .cpu_reset_req(cpu_reset_req),
        .wdt_irq(wdt_irq), .wdt_timeout(wdt_timeout));
    task automatic chk(input [7:0] e, input [7:0] got);
        num_checks++;
        if (got !== e) begin
            fail_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, got);
        end
    endtask
    task automatic end_of_test;
        if (exp_q.size() != 0) fail_count++;
        if (fail_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // read data lands one cycle after an accepted read
    always @(negedge ref_clk) begin
        if (hit_d === 1'b1) begin
            if (exp_q.size() == 0) fail_count++;
            else chk(exp_q.pop_front(), io_rdata);
        end
        hit_d = io_rd_hit;
    end
    task automatic rix(input [15:0] a, input [7:0] i, input [7:0] e);
        host.wr(a, i);
        exp_q.push_back(e);
        host.rd(a + 16'h0001);
    endtask
    task automatic wait_to(input int lim);
        c = 0;
        while (wdt_timeout !== 1'b1 && c < lim) begin
            @(negedge ref_clk);
            c++;
        end
        if (c >= lim) begin
            fail_count++;
            end_of_test();
        end
    endtask
    initial begin
        #2000000;
        fail_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h6b2c));
        g = 8'($urandom);
        v = 8'($urandom);
        p = 8'($urandom);
        gpio_in <= g;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        chk(8'hff, gpio_oe_n);
        chk(8'h00, gpio_out);
        host.rd(16'h002f);
        host.enter(16'h002e, 8'h87);
        exp_q.push_back(8'h00);
        host.rd(16'h002f);
        host.cfg(16'h002e, 8'h07, 8'h07);
        rix(16'h002e, 8'hf0, 8'hff);
        rix(16'h002e, 8'hf2, 8'h00);
        rix(16'h002e, 8'hf1, g);
        host.leave(16'h002e);
        host.rd(16'h002f);
        host.enter(16'h004e, 8'h77);
        host.cfg(16'h004e, 8'hf0, 8'hf0);
        host.cfg(16'h004e, 8'hf2, p);
        host.cfg(16'h004e, 8'hf1, v);
        g = 8'($urandom);
        gpio_in <= g;
        rix(16'h004e, 8'hf1, {g[7:4] ^ p[7:4], v[3:0]});
        host.idle(2);
        chk(8'hf0, gpio_oe_n);
        chk((v ^ p) & 8'h0f, gpio_out & 8'h0f);
        host.cfg(16'h004e, 8'h07, 8'h08);
        host.cfg(16'h004e, 8'h30, 8'h01);
        host.leave(16'h004e);
        for (int i = 0; i < 3; i++) begin
            wdt_irq_mode <= i[0];
            host.wr(16'h0300, uc[i]);
            host.wr(16'h0301, 8'h03);
            host.idle(0);
            wait_to(3 * tk[i] + 8);
            num_checks++;
            if (c < 3 * tk[i] - 1 || c > 3 * tk[i] + 3) begin
                fail_count++;
                $display("BAD t=%0t exp=%h got=%h", $time, 3 * tk[i], c);
            end
            chk({6'h00, ~i[0], i[0]}, {6'h00, cpu_reset_req, wdt_irq});
            @(posedge ref_clk);
        end
        host.wr(16'h0300, 8'h03);
        host.idle(2);
        chk(8'h00, {7'h00, wdt_timeout});
        host.wr(16'h0300, 8'h00);
        host.wr(16'h0301, 8'h03);
        host.enter(16'h004e, 8'h77);
        host.cfg(16'h004e, 8'h07, 8'h08);
        host.cfg(16'h004e, 8'h30, 8'h00);
        host.leave(16'h004e);
        host.wr(16'h0300, 8'h00);
        host.wr(16'h0301, 8'h02);
        host.idle(20);
        chk(8'h00, {7'h00, wdt_timeout});
        end_of_test();
    end
endmodule // superio_gpio_watchdog_tb_top
bind sgw_top sgw_chk chk_i (.ref_clk(ref_clk), .resetn(resetn), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .io_rd_hit(io_rd_hit), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .cpu_reset_req(cpu_reset_req), .wdt_irq(wdt_irq), .wdt_timeout(wdt_timeout));
